// [core/mosc_counter.v]
// multiframe out-of-sync / framing-bit error performance counter with register port
//
// Notes on behaviour
// - select=1 counts each receive multiframe spent out of sync, D4 or ESF.
// - multiframe out-of-sync counting continues while receive sync is lost.
// - select=0 counts Ft errors in D4, FPS errors in ESF.
// - framing-bit error counting halts while receive sync is lost.
// - select bit 0 picks framing-bit errors, 1 picks multiframes out of sync.
// - 12-bit count: bits 11..8 in 0x25 bits 7..4, low byte at 0x27.
// - bits 3..0 of 0x25 return the path violation counter's top nibble.
// - readable count updates each second, or every 42 ms when interval bit set.
// - counter saturates at its maximum and never wraps to zero.
// - framing mode bit 1 means ESF, 0 means D4.
`timescale 1ns/10ps
`include "mosc_defs.vh"

module mosc_counter #(
  parameter CNT_W     = `MOSC_CNT_W,
  parameter LONG_CYC  = `MOSC_LONG_CYC,
  parameter SHORT_CYC = `MOSC_SHORT_CYC
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       rstn_i,
  // register port
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output wire [7:0] rdata_o,
  // receive framer events, one-cycle pulses, plus the sync-lost level
  input  wire       mf_boundary_i,
  input  wire       rx_sync_lost_i,
  input  wire       ft_error_i,
  input  wire       fps_error_i,
  // path violation counter top nibble
  input  wire [3:0] path_violation_counter_i,
  // boundary indication
  output wire       update_o
);

  //////////////////////////////////////////////////////////////////////////////

  reg  [7:0]       ctrl_r;
  reg  [CNT_W-1:0] accum_r;
  reg  [CNT_W-1:0] accum_nxt;
  reg  [CNT_W-1:0] count_r;
  reg  [7:0]       rdata_r;
  reg  [7:0]       rdata_nxt;
  reg              update_r;
  wire             count_select_bit;
  wire             framing_mode_bit;
  wire             update_interval_bit;
  wire             tick;
  wire             fbit_err;
  wire             event_hit;
  wire [CNT_W-1:0] cnt_max;

  assign count_select_bit    = ctrl_r[`MOSC_CTRL_SEL_BIT];
  assign framing_mode_bit    = ctrl_r[`MOSC_CTRL_ESF_BIT];
  assign update_interval_bit = ctrl_r[`MOSC_CTRL_INT_BIT];
  assign cnt_max             = {CNT_W{1'b1}};

  //////////////////////////////////////////////////////////////////////////////

  mosc_interval_timer #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_timer (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .short_i (update_interval_bit),
    .tick_o  (tick)
  );

  //////////////////////////////////////////////////////////////////////////////

  // framing pattern in use depends on framing mode
  assign fbit_err = framing_mode_bit ? fps_error_i : ft_error_i;

  // out-of-sync mode counts only while sync is lost; error mode is gated off by it
  assign event_hit = count_select_bit ? (mf_boundary_i & rx_sync_lost_i)
                                      : (fbit_err & ~rx_sync_lost_i);

  always @*
  begin
    accum_nxt = accum_r;
    if (tick)
      // an event in the boundary cycle is charged to the new interval
      accum_nxt = event_hit ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
    else if (event_hit && (accum_r != cnt_max))
      accum_nxt = accum_r + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      accum_r  <= {CNT_W{1'b0}};
      count_r  <= {CNT_W{1'b0}};
      update_r <= 1'b0;
    end
    else
    begin
      accum_r  <= accum_nxt;
      update_r <= tick;
      if (tick)
        count_r <= accum_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_r <= `MOSC_CTRL_RESET;
    else if (wr_i && (addr_i == `MOSC_ADDR_CTRL))
      ctrl_r <= {5'h00, wdata_i[2:0]};
  end

  always @*
  begin
    rdata_nxt = 8'h00;
    if (addr_i == `MOSC_ADDR_HIGH)
      rdata_nxt = {count_r[11:8], path_violation_counter_i};
    else if (addr_i == `MOSC_ADDR_LOW)
      rdata_nxt = count_r[7:0];
    else if (addr_i == `MOSC_ADDR_CTRL)
      rdata_nxt = ctrl_r;
    else if (addr_i == `MOSC_ADDR_STAT)
      rdata_nxt = {7'h00, rx_sync_lost_i};
  end

  // read data valid the cycle after the strobe only
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_r <= 8'h00;
    else if (rd_i)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 8'h00;
  end

  assign rdata_o  = rdata_r;
  assign update_o = update_r;

endmodule

// [core/mosc_defs.vh]
// constants for the multiframe out-of-sync / framing-bit error counter
`ifndef MOSC_DEFS_VH
`define MOSC_DEFS_VH

// register byte addresses
`define MOSC_ADDR_HIGH      8'h25
`define MOSC_ADDR_LOW       8'h27
`define MOSC_ADDR_CTRL      8'h28
`define MOSC_ADDR_STAT      8'h29

// control register field positions
`define MOSC_CTRL_SEL_BIT   0
`define MOSC_CTRL_ESF_BIT   1
`define MOSC_CTRL_INT_BIT   2
`define MOSC_CTRL_RESET     8'h00

// counter geometry
`define MOSC_CNT_W          12
`define MOSC_CNT_MAX        12'hfff

// update intervals
`define MOSC_CLK_MHZ        100
`define MOSC_LONG_MS        1000
`define MOSC_SHORT_MS       42
`define MOSC_LONG_CYC       (`MOSC_LONG_MS * 1000 * `MOSC_CLK_MHZ)
`define MOSC_SHORT_CYC      (`MOSC_SHORT_MS * 1000 * `MOSC_CLK_MHZ)

`endif

// [core/mosc_interval_timer.v]
// interval timer producing one-cycle update boundary pulses
`timescale 1ns/10ps
`include "mosc_defs.vh"

module mosc_interval_timer #(
  parameter LONG_CYC  = `MOSC_LONG_CYC,
  parameter SHORT_CYC = `MOSC_SHORT_CYC
) (
  // clock and reset
  input  wire clk_i,
  input  wire rstn_i,
  // control
  input  wire short_i,
  // boundary pulse
  output wire tick_o
);

  reg  [31:0] cnt_r;
  wire [31:0] limit;

  // interval change takes effect at once; a longer count is cut short by the compare
  assign limit  = short_i ? SHORT_CYC - 32'h1 : LONG_CYC - 32'h1;
  assign tick_o = (cnt_r >= limit);

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_r <= 32'h0;
    else if (tick_o)
      cnt_r <= 32'h0;
    else
      cnt_r <= cnt_r + 32'h1;
  end

endmodule

// [testbench/mosc_counter_sva.sv]
// concurrent checks on the counter's register port and update pulse
`timescale 1ns/10ps
module mosc_counter_sva (
  input wire       clk_i,
  input wire       rstn_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       rx_sync_lost_i,
  input wire [3:0] path_violation_counter_i,
  input wire       update_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not idle");
  a_shared_nibble: assert property (rd_i && addr_i == 8'h25 |=> rdata_o[3:0] == $past(path_violation_counter_i))
    else $error("low nibble of 0x25 wrong");
  a_unmapped_zero: assert property (rd_i && !(addr_i inside {8'h25, 8'h27, 8'h28, 8'h29}) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_update_single: assert property (update_o |=> !update_o [*8])
    else $error("update pulse too close");
  a_ctrl_back: assert property (wr_i && addr_i == 8'h28 ##1 rd_i && addr_i == 8'h28
    |=> rdata_o == {5'h00, $past(wdata_i[2:0], 2)})
    else $error("control readback wrong");
  a_ctrl_upper: assert property (rd_i && addr_i == 8'h28 |=> rdata_o[7:3] == 5'h00)
    else $error("control upper bits set");
  a_stat_sync: assert property (rd_i && addr_i == 8'h29 |=> rdata_o == {7'h00, $past(rx_sync_lost_i)})
    else $error("status wrong");
endmodule
bind mosc_counter mosc_counter_sva u_sva (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .rx_sync_lost_i, .path_violation_counter_i, .update_o);

// [testbench/testbench.sv]
// self-checking bench for the multiframe error counter
`timescale 1ns/10ps
module testbench;
  reg        clk_i, rstn_i, wr_i, rd_i, mf, sl, ft, fps;
  reg  [7:0] addr_i, wdata_i;
  reg  [3:0] pvc;
  reg        wr2, ft2;
  wire [7:0] rdata_o;
  wire [7:0] rdata2;
  wire       upd;
  wire       upd2;
  integer    num_errors, tests_run, cyc, k, m, g;
  mosc_counter #(.LONG_CYC(200), .SHORT_CYC(50)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mf_boundary_i(mf), .rx_sync_lost_i(sl),
    .ft_error_i(ft), .fps_error_i(fps), .path_violation_counter_i(pvc), .update_o(upd));
  // second counter fed an error every cycle over a long interval, so it must saturate
  mosc_counter #(.LONG_CYC(4200), .SHORT_CYC(50)) dut_sat (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr2), .rd_i(rd_i), .rdata_o(rdata2), .mf_boundary_i(mf), .rx_sync_lost_i(sl),
    .ft_error_i(ft2), .fps_error_i(fps), .path_violation_counter_i(pvc), .update_o(upd2));
  task final_report;
    begin
      if (num_errors == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [7:0] s, input [7:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e)
      begin
        num_errors = num_errors + 1;
        $display("ERROR %0t saw %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
    end
  endtask
  task rd2(input [7:0] a, input [7:0] e);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata2, e);
    end
  endtask
  task wu;
    begin
      g = 0;
      do
      begin
        @(posedge clk_i);
        #1 g = g + 1;
      end while (upd !== 1'b1 && g < 500);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // ft and mf straddle the sync-loss edge so both gating modes show
  task burst;
    begin
      for (k = 0; k < 11; k = k + 1)
      begin
        @(posedge clk_i);
        sl <= k >= 4 && k < 10;
        ft <= k <= 5;
        fps <= k < 2;
        mf <= k >= 3 && k < 10;
      end
    end
  endtask
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 10000)
    begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  initial
  begin
    {rstn_i, wr_i, rd_i, mf, sl, ft, fps} = 7'h00;
    {addr_i, wdata_i, pvc} = 20'h00000;
    {num_errors, tests_run, cyc} = 0;
    {wr2, ft2} = 2'b01;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(8'h28, 8'h00);
    rd(8'h29, 8'h00);
    rd(8'h3f, 8'h00);
    wu;
    wu;
    chk(g, 200);
    for (m = 0; m < 4; m = m + 1)
    begin
      pvc <= 4'h9 ^ m[3:0];
      wr(8'h28, 8'h04 | m[7:0]);
      rd(8'h28, 8'h04 | m[7:0]);
      wu;
      burst;
      wu;
      wr(8'h27, 8'hff);
      rd(8'h27, m[0] ? 8'h06 : (m[1] ? 8'h02 : 8'h04));
      rd(8'h25, {4'h0, pvc});
      wu;
      wu;
      chk(g, 50);
      rd(8'h27, 8'h00);
    end
    do
    begin
      @(posedge clk_i);
      #1;
    end while (upd2 !== 1'b1);
    rd2(8'h27, 8'hff);
    rd2(8'h25, {4'hf, pvc});
    final_report;
  end
endmodule
